// File: bench/cmc_props.sv
// Concurrent checks on the link between the portable and fixed ends
`default_nettype none
module cmc_props
  import cmc_pkg::*;
#(
  parameter int FRAME_CYCLES = 20
) (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        frame_tick,
  input wire logic [3:0]  frame_num,
  input wire logic [23:0] multiframe_num,
  input wire logic        pt_msg_vld,
  input var  cmc_msg_t    pt_msg,
  input wire logic        ft_msg_vld,
  input var  cmc_msg_t    ft_msg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================
  // Handshake counters, cleared by the answer from the far end
  logic       pt_req;
  logic       pt_grant;
  logic       ft_conf;
  logic [2:0] req_cnt;
  logic [2:0] conf_cnt;
  assign pt_req = pt_msg_vld && (pt_msg == CMC_MSG_STOP_REQ || pt_msg == CMC_MSG_START_REQ);
  assign pt_grant = pt_msg_vld && (pt_msg == CMC_MSG_STOP_GRANT || pt_msg == CMC_MSG_START_GRANT);
  assign ft_conf = ft_msg_vld && (ft_msg == CMC_MSG_CIPHER_HALT_CONFIRM || ft_msg == CMC_MSG_START_CONF);
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || ft_conf) begin
      req_cnt <= 3'h0;
    end else if (pt_req) begin
      req_cnt <= req_cnt + 3'h1;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || pt_grant) begin
      conf_cnt <= 3'h0;
    end else if (ft_conf) begin
      conf_cnt <= conf_cnt + 3'h1;
    end
  end
  // ==========================================================
  // Assertions
  pt_parity_a:
    assert property (pt_msg_vld |-> $past(frame_tick) && !frame_num[0])
    else $error("portable message outside an even frame");
  ft_parity_a:
    assert property (ft_msg_vld |-> $past(frame_tick) && frame_num[0])
    else $error("fixed message outside an odd frame");
  tick_pulse_a:
    assert property (frame_tick |=> (!frame_tick) [*8])
    else $error("frame tick repeated too soon");
  frame_step_a:
    assert property (frame_tick |-> frame_num == $past(frame_num) + 4'h1)
    else $error("frame number did not step on tick");
  mframe_step_a:
    assert property (frame_tick && frame_num == 4'h0 |->
      multiframe_num == $past(multiframe_num) + 24'h1)
    else $error("multiframe number did not step on wrap");
  conf_answer_a:
    assert property (pt_req |-> ##FRAME_CYCLES ft_msg_vld && ft_msg ==
      ($past(pt_msg, FRAME_CYCLES) == CMC_MSG_STOP_REQ ? CMC_MSG_CIPHER_HALT_CONFIRM : CMC_MSG_START_CONF))
    else $error("request not confirmed in the next odd frame");
  grant_answer_a:
    assert property (ft_conf |-> ##FRAME_CYCLES pt_grant && pt_msg ==
      ($past(ft_msg, FRAME_CYCLES) == CMC_MSG_CIPHER_HALT_CONFIRM ? CMC_MSG_STOP_GRANT : CMC_MSG_START_GRANT))
    else $error("confirm not granted in the next even frame");
  grant_cause_a:
    assert property (pt_grant |-> $past(ft_conf, FRAME_CYCLES))
    else $error("grant without a confirm one frame earlier");
  req_limit_a:
    assert property (pt_req |-> req_cnt < 3'h5)
    else $error("more than five requests sent");
  conf_limit_a:
    assert property (ft_conf |-> conf_cnt < 3'h6)
    else $error("more than six confirms sent");
  cover property (pt_msg_vld && pt_msg == CMC_MSG_STOP_GRANT);
  cover property (pt_msg_vld && pt_msg == CMC_MSG_START_GRANT);
  cover property (pt_req ##FRAME_CYCLES ft_conf);
endmodule // cmc_props
`default_nettype wire

// File: bench/cmc_tb.sv
// Self-checking bench for the portable and fixed controller pair
`default_nettype none
module testbench import cmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FC = 20;
  logic        core_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  pulses = 4'h0;
  logic [63:0] new_key_in = 64'h1111;
  logic [9:0]  bit_idx_in = 10'h0;
  logic        prot_fmt_in = 1'b0;
  logic [9:0]  j_len_in = 10'h0;
  logic        p_cfm, p_rel, p_con, p_dec, p_dis, p_ok, p_busy, p_ks, q_rel, q_con, q_busy;
  logic        f_ind, f_rel, f_con, f_dec, f_dis, f_ks, ans_en;
  logic        rel_seen = 1'b0;
  logic [63:0] p_key, f_key;
  logic [34:0] p_iv, f_iv;
  logic [4:0]  dcnt;
  logic [7:0]  log_q[$];
  logic [7:0]  rk [6];
  logic [20:0] tbl [10] = '{{1'b1, 10'h2a0, 10'h03f}, {1'b1, 10'h2a0, 10'h040},
    {1'b1, 10'h2a0, 10'h050}, {1'b1, 10'h2a0, 10'h27f}, {1'b1, 10'h2a0, 10'h280},
    {1'b1, 10'h2a0, 10'h29c}, {1'b1, 10'h280, 10'h21f}, {1'b1, 10'h280, 10'h230},
    {1'b0, 10'h280, 10'h27f}, {1'b0, 10'h280, 10'h280}};
  int          mismatches = 0;
  int          num_checks = 0;
  int          n_req2 = 0;
  always #5 core_clk_in = ~core_clk_in;
  // ==========================================================
  // Design pair and a stand-in fixed end that answers only while ans_en is set
  cmc_link_if link ();
  cmc_link_if link2 ();
  cmc_portable u_cmc_portable (.core_clk_in, .rst_n_in, .link(link.portable),
    .mode_switch_request_prim_in(pulses[0]), .rekey_request_in(pulses[1]), .new_key_in,
    .new_connection_in(pulses[2]), .bit_idx_in, .prot_fmt_in, .j_len_in,
    .mode_switch_confirm_prim_out(p_cfm), .link_release_indication_out(p_rel),
    .cipher_on_out(p_con), .rx_decrypt_out(p_dec), .rx_discard_out(p_dis),
    .old_conn_release_ok_out(p_ok), .busy_out(p_busy), .cipher_key_out(p_key),
    .init_value_out(p_iv), .ks_apply_out(p_ks));
  cmc_fixed #(.FRAME_CYCLES(FC)) u_cmc_fixed (.core_clk_in, .rst_n_in, .link(link.fixed),
    .cipher_key_in(new_key_in), .new_connection_in(pulses[2]), .bit_idx_in, .prot_fmt_in,
    .j_len_in, .mode_switch_indication_prim_out(f_ind), .link_release_indication_out(f_rel),
    .cipher_on_out(f_con), .rx_decrypt_out(f_dec), .rx_discard_out(f_dis),
    .cipher_key_out(f_key), .init_value_out(f_iv), .ks_apply_out(f_ks));
  cmc_portable u_cmc_portable_2 (.core_clk_in, .rst_n_in, .link(link2.portable),
    .mode_switch_request_prim_in(pulses[3]), .rekey_request_in(pulses[1]), .new_key_in,
    .new_connection_in(pulses[2]), .bit_idx_in, .prot_fmt_in, .j_len_in,
    .mode_switch_confirm_prim_out(), .link_release_indication_out(q_rel),
    .cipher_on_out(q_con), .rx_decrypt_out(), .rx_discard_out(), .old_conn_release_ok_out(),
    .busy_out(q_busy), .cipher_key_out(), .init_value_out(), .ks_apply_out());
  cmc_props #(.FRAME_CYCLES(FC)) u_cmc_props (.core_clk_in, .rst_n_in,
    .frame_tick(link.frame_tick), .frame_num(link.frame_num),
    .multiframe_num(link.multiframe_num), .pt_msg_vld(link.pt_msg_vld),
    .pt_msg(link.pt_msg), .ft_msg_vld(link.ft_msg_vld), .ft_msg(link.ft_msg));
  assign link2.multiframe_num = 24'h0;
  assign link2.ft_msg = CMC_MSG_START_CONF;
  always @(negedge core_clk_in) begin
    dcnt <= (!rst_n_in || dcnt == 5'(FC - 1)) ? 5'h0 : dcnt + 5'h1;
    if (!rst_n_in) link2.frame_num <= 4'h0;
    else if (dcnt == 5'(FC - 1)) link2.frame_num <= link2.frame_num + 4'h1;
    link2.frame_tick <= rst_n_in && dcnt == 5'(FC - 1);
    link2.ft_msg_vld <= ans_en && link2.frame_tick && link2.frame_num[0];
    if (link.pt_msg_vld) log_q.push_back({link.frame_num, 1'b0, 3'(link.pt_msg)});
    if (link.ft_msg_vld) log_q.push_back({link.frame_num, 1'b1, 3'(link.ft_msg)});
    n_req2 += int'(link2.pt_msg_vld);
    // Sticky, so a one-cycle release pulse on the answered pair is not missed
    rel_seen <= rst_n_in && (rel_seen || p_rel || f_rel);
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return link.pt_msg_vld;
      1: return link.ft_msg_vld;
      2: return !p_busy;
      3: return !q_busy;
      4: return link2.pt_msg_vld;
      default: return q_rel;
    endcase
  endfunction
  // Bounded so a lost handshake counts a mismatch and moves on instead of hanging
  task automatic wait_on(input int w);
    int n;
    n = 0;
    @(negedge core_clk_in);
    while (sel(w) !== 1'b1 && n < 16 * FC) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n == 16 * FC) mismatches++;
  endtask
  task automatic pulse(input int i);
    @(negedge core_clk_in);
    pulses[i] = 1'b1;
    @(negedge core_clk_in);
    pulses = 4'h0;
  endtask
  task automatic idle();
    wait_on(2);
    repeat (2) @(negedge core_clk_in);
  endtask
  function automatic logic exp_ks(input logic [20:0] e);
    int j;
    int k;
    j = int'(e[19:10]);
    k = int'(e[9:0]);
    if (!e[20]) return k < j;
    return k < j / 80 * 80 && k % 80 < 64;
  endfunction
  // ==========================================================
  // Scenarios
  initial begin
    #(300 * FC * 10);
    mismatches++;
    wrap_up();
  end
  initial begin
    ans_en = 1'b0;
    link2.frame_tick = 1'b0;
    link2.ft_msg_vld = 1'b0;
    rk = '{8'h03, 8'h1c, 8'h25, 8'h40, 8'h59, 8'h62};
    repeat (6) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    pulse(0);
    wait_on(0);
    idle();
    check({p_con, f_con, p_dec, f_dec}, 4'hf);
    check(p_iv, {7'h0, link.multiframe_num, link.frame_num});
    check(f_iv, p_iv);
    foreach (tbl[i]) begin
      {prot_fmt_in, j_len_in, bit_idx_in} = tbl[i];
      @(negedge core_clk_in);
      check({p_ks, f_ks}, {2{exp_ks(tbl[i])}});
    end
    pulse(0);
    wait_on(0);
    check({link.pt_msg, link.frame_num[0]}, {CMC_MSG_STOP_REQ, 1'b0});
    @(negedge core_clk_in);
    check({f_con, p_dis}, 2'b01);
    wait_on(1);
    check({link.ft_msg, f_dec}, {CMC_MSG_CIPHER_HALT_CONFIRM, 1'b1});
    @(negedge core_clk_in);
    check({p_cfm, p_dec, p_dis, p_con}, 4'b1001);
    wait_on(0);
    check({link.pt_msg, p_con, f_dis}, {CMC_MSG_STOP_GRANT, 2'b01});
    @(negedge core_clk_in);
    check({f_ind, f_dec, f_dis, f_con}, 4'b1000);
    idle();
    pulse(0);
    wait_on(0);
    idle();
    new_key_in = 64'h0123456789abcdef;
    log_q.delete();
    pulse(1);
    for (int k = 0; k < 16 * FC && log_q.size() < 6; k++) @(negedge core_clk_in);
    repeat (2) @(negedge core_clk_in);
    foreach (rk[i]) check(log_q[i], {log_q[0][7:4] + rk[i][7:4], rk[i][3:0]});
    check(p_key, 64'h0123456789abcdef);
    check({p_con, f_con}, 2'b11);
    check(f_key, p_key);
    pulse(2);
    @(negedge core_clk_in);
    check({p_con, f_con, p_dec, f_dec, p_ok}, 5'h0);
    pulse(0);
    wait_on(0);
    idle();
    check({p_con, f_con, p_ok}, 3'b111);
    ans_en = 1'b1;
    pulse(3);
    wait_on(4);
    wait_on(3);
    ans_en = 1'b0;
    check(q_con, 1'b1);
    repeat (2) @(negedge core_clk_in);
    n_req2 = 0;
    pulse(3);
    wait_on(5);
    check({q_rel, q_con}, 2'b11);
    check(n_req2, 5);
    check(rel_seen, 1'b0);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire

// File: hw/cmc_defines.svh
// Constants for the cipher mode stop and re-key controller
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH

// ==========================================================
// Timing
`define CMC_CLK_MHZ         100
`define CMC_FRAME_PERIOD_US 10000
`define CMC_FRAME_CYCLES    (`CMC_FRAME_PERIOD_US * `CMC_CLK_MHZ)

// ==========================================================
// Handshake counts
`define CMC_REQ_REPEAT      3'd5
`define CMC_CONF_REPEAT     3'd6

// ==========================================================
// Protected B-field layout
`define CMC_SUBFIELD_BITS   10'd80
`define CMC_SUBFIELD_DATA   10'd64
`define CMC_X_BITS          10'd4
`define CMC_PAD_J           10'd672

`endif

// File: hw/cmc_fixed.sv
// Fixed-side end: frame timing, confirmation and grant handling
`default_nettype none
`include "cmc_defines.svh"

module cmc_fixed
  import cmc_pkg::*;
#(
  parameter int FRAME_CYCLES = `CMC_FRAME_CYCLES
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  cmc_link_if.fixed        link,
  input  wire logic [63:0] cipher_key_in,
  input  wire logic        new_connection_in,
  input  wire logic [9:0]  bit_idx_in,
  input  wire logic        prot_fmt_in,
  input  wire logic [9:0]  j_len_in,
  output logic             mode_switch_indication_prim_out,
  output logic             link_release_indication_out,
  output logic             cipher_on_out,
  output logic             rx_decrypt_out,
  output logic             rx_discard_out,
  output logic [63:0]      cipher_key_out,
  output logic [34:0]      init_value_out,
  output logic             ks_apply_out
);

  cmc_ft_state_t state;
  logic [31:0]   div_cnt;
  logic [2:0]    conf_cnt;
  logic          op_stop;
  logic          odd_tick;
  logic          even_tick;
  logic          req_seen;
  logic          grant_seen;
  logic          timeout;

  // ==========================================================
  // Frame timing
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      div_cnt             <= 32'h0;
      link.frame_tick     <= 1'b0;
      link.frame_num      <= 4'h0;
      link.multiframe_num <= 24'h0;
    end else begin
      link.frame_tick <= 1'b0;
      if (div_cnt == 32'(FRAME_CYCLES - 1)) begin
        div_cnt         <= 32'h0;
        link.frame_tick <= 1'b1;
        link.frame_num  <= 4'(link.frame_num + 4'h1);
        if (link.frame_num == 4'hf) begin
          link.multiframe_num <= 24'(link.multiframe_num + 24'h1);
        end
      end else begin
        div_cnt <= 32'(div_cnt + 32'h1);
      end
    end
  end

  assign odd_tick   = link.frame_tick && link.frame_num[0];
  assign even_tick  = link.frame_tick && !link.frame_num[0];
  assign req_seen   = link.pt_msg_vld && (link.pt_msg == CMC_MSG_STOP_REQ ||
                      link.pt_msg == CMC_MSG_START_REQ);
  assign grant_seen = link.pt_msg_vld && (link.pt_msg == (op_stop ?
                      CMC_MSG_STOP_GRANT : CMC_MSG_START_GRANT));
  // Sixth confirm went out in 2S+11; next even frame ends the wait
  assign timeout    = even_tick && conf_cnt == `CMC_CONF_REPEAT;

  // ==========================================================
  // Handshake sequencing
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state    <= FT_IDLE;
      conf_cnt <= 3'h0;
      op_stop  <= 1'b0;
    end else begin
      unique case (state)
        FT_IDLE: begin
          if (req_seen) begin
            state    <= FT_CONF;
            conf_cnt <= 3'h0;
            op_stop  <= link.pt_msg == CMC_MSG_STOP_REQ;
          end
        end
        FT_CONF: begin
          if (grant_seen || timeout) begin
            state <= FT_IDLE;
          end else if (odd_tick && conf_cnt < `CMC_CONF_REPEAT) begin
            conf_cnt <= 3'(conf_cnt + 3'h1);
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Confirm transmission, odd frames only, never ciphered
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      link.ft_msg_vld <= 1'b0;
      link.ft_msg     <= CMC_MSG_CIPHER_HALT_CONFIRM;
    end else begin
      link.ft_msg_vld <= 1'b0;
      if (state == FT_CONF && !grant_seen && odd_tick &&
          conf_cnt < `CMC_CONF_REPEAT) begin
        link.ft_msg_vld <= 1'b1;
        link.ft_msg     <= op_stop ? CMC_MSG_CIPHER_HALT_CONFIRM : CMC_MSG_START_CONF;
      end
    end
  end

  // ==========================================================
  // Mode, discard and upward events
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cipher_on_out                   <= 1'b0;
      rx_decrypt_out                  <= 1'b0;
      rx_discard_out                  <= 1'b0;
      mode_switch_indication_prim_out <= 1'b0;
      link_release_indication_out     <= 1'b0;
    end else begin
      mode_switch_indication_prim_out <= 1'b0;
      link_release_indication_out     <= 1'b0;
      if (new_connection_in) begin
        cipher_on_out  <= 1'b0;
        rx_decrypt_out <= 1'b0;
        rx_discard_out <= 1'b0;
      end else if (state == FT_IDLE && req_seen) begin
        cipher_on_out <= link.pt_msg == CMC_MSG_START_REQ;
      end else if (state == FT_CONF) begin
        if (grant_seen) begin
          rx_decrypt_out                  <= !op_stop;
          rx_discard_out                  <= 1'b0;
          mode_switch_indication_prim_out <= 1'b1;
        end else if (timeout) begin
          rx_discard_out              <= 1'b0;
          link_release_indication_out <= 1'b1;
        end else if (even_tick && conf_cnt != 3'h0) begin
          // Frame 2S+1 was still taken in the old mode
          rx_discard_out <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Keystream setup and B-field mask
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cipher_key_out <= 64'h0;
      init_value_out <= 35'h0;
      ks_apply_out   <= 1'b0;
    end else begin
      cipher_key_out <= cipher_key_in;
      init_value_out <= {7'h00, link.multiframe_num, link.frame_num};
      ks_apply_out   <= cipher_on_out &&
                        cmc_bit_ciphered(bit_idx_in, prot_fmt_in, j_len_in);
    end
  end

endmodule : cmc_fixed

`default_nettype wire

// File: hw/cmc_link_if.sv
// Air-side link between the portable and fixed ends
`default_nettype none

interface cmc_link_if;
  import cmc_pkg::*;

  logic              frame_tick;
  logic [3:0]        frame_num;
  logic [23:0]       multiframe_num;
  logic              pt_msg_vld;
  cmc_msg_t          pt_msg;
  logic              ft_msg_vld;
  cmc_msg_t          ft_msg;

  modport portable (
    input  frame_tick, frame_num, multiframe_num, ft_msg_vld, ft_msg,
    output pt_msg_vld, pt_msg
  );

  modport fixed (
    output frame_tick, frame_num, multiframe_num, ft_msg_vld, ft_msg,
    input  pt_msg_vld, pt_msg
  );

endinterface : cmc_link_if

`default_nettype wire

// File: hw/cmc_pkg.sv
// Types and field decode shared by both ends of the controller
`default_nettype none
`include "cmc_defines.svh"

package cmc_pkg;

  typedef enum logic [2:0] {
    CMC_MSG_START_REQ,
    CMC_MSG_START_CONF,
    CMC_MSG_START_GRANT,
    CMC_MSG_STOP_REQ,
    CMC_MSG_CIPHER_HALT_CONFIRM,
    CMC_MSG_STOP_GRANT
  } cmc_msg_t;

  typedef enum {PT_IDLE, PT_REQ, PT_GRANT} cmc_pt_state_t;
  typedef enum {FT_IDLE, FT_CONF} cmc_ft_state_t;

  // Whether B-field bit idx takes keystream
  function automatic logic cmc_bit_ciphered(input logic [9:0] idx,
                                            input logic       prot,
                                            input logic [9:0] j_len);
    logic [9:0] nsub;
    logic [9:0] area;
    // X-field sits beyond the j bits; only whole 80-bit subfields within j count
    nsub = j_len / `CMC_SUBFIELD_BITS;
    area = 10'(nsub * `CMC_SUBFIELD_BITS);
    if (!prot) begin
      return idx < j_len;
    end
    // Padding and X-field fall beyond the subfield area
    if (idx >= area) begin
      return 1'b0;
    end
    return (idx % `CMC_SUBFIELD_BITS) < `CMC_SUBFIELD_DATA;
  endfunction

endpackage : cmc_pkg

`default_nettype wire

// File: hw/cmc_portable.sv
// Portable-side end: initiates stop, start and re-key handshakes
`default_nettype none
`include "cmc_defines.svh"

module cmc_portable
  import cmc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  cmc_link_if.portable     link,
  input  wire logic        mode_switch_request_prim_in,
  input  wire logic        rekey_request_in,
  input  wire logic [63:0] new_key_in,
  input  wire logic        new_connection_in,
  input  wire logic [9:0]  bit_idx_in,
  input  wire logic        prot_fmt_in,
  input  wire logic [9:0]  j_len_in,
  output logic             mode_switch_confirm_prim_out,
  output logic             link_release_indication_out,
  output logic             cipher_on_out,
  output logic             rx_decrypt_out,
  output logic             rx_discard_out,
  output logic             old_conn_release_ok_out,
  output logic             busy_out,
  output logic [63:0]      cipher_key_out,
  output logic [34:0]      init_value_out,
  output logic             ks_apply_out
);

  cmc_pt_state_t state;
  logic [2:0]    req_cnt;
  logic          op_stop;
  logic          rekey_pend;
  logic          handover_leg;
  logic          even_tick;
  logic          conf_seen;
  logic          send_req;
  logic          send_grant;
  logic          timeout;
  logic          begin_op;
  logic          begin_rekey;
  logic          key_load;

  // ==========================================================
  // Frame and message decode
  assign even_tick   = link.frame_tick && !link.frame_num[0];
  assign conf_seen   = state == PT_REQ && req_cnt != 3'h0 && link.ft_msg_vld &&
                       link.ft_msg == (op_stop ? CMC_MSG_CIPHER_HALT_CONFIRM :
                       CMC_MSG_START_CONF);
  // Five requests sent and the following even frame came with no confirm
  assign timeout     = state == PT_REQ && !conf_seen && even_tick &&
                       req_cnt == `CMC_REQ_REPEAT;
  assign send_req    = state == PT_REQ && !conf_seen && even_tick &&
                       req_cnt < `CMC_REQ_REPEAT;
  assign send_grant  = state == PT_GRANT && even_tick;
  assign begin_op    = state == PT_IDLE && mode_switch_request_prim_in;
  assign begin_rekey = state == PT_IDLE && !mode_switch_request_prim_in &&
                       rekey_request_in && cipher_on_out;
  // New key is activated when a start handshake begins
  assign key_load    = (begin_op && !cipher_on_out) ||
                       (send_grant && rekey_pend);

  // ==========================================================
  // Handshake sequencing
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state      <= PT_IDLE;
      req_cnt    <= 3'h0;
      op_stop    <= 1'b0;
      rekey_pend <= 1'b0;
    end else begin
      unique case (state)
        PT_IDLE: begin
          if (begin_op || begin_rekey) begin
            state      <= PT_REQ;
            req_cnt    <= 3'h0;
            op_stop    <= cipher_on_out;
            rekey_pend <= begin_rekey;
          end
        end
        PT_REQ: begin
          if (conf_seen) begin
            state <= PT_GRANT;
          end else if (timeout) begin
            state      <= PT_IDLE;
            rekey_pend <= 1'b0;
          end else if (send_req) begin
            req_cnt <= 3'(req_cnt + 3'h1);
          end
        end
        PT_GRANT: begin
          if (send_grant) begin
            if (rekey_pend) begin
              // Restart with the new key right after the stop grant
              state      <= PT_REQ;
              req_cnt    <= 3'h0;
              op_stop    <= 1'b0;
              rekey_pend <= 1'b0;
            end else begin
              state <= PT_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Message transmission, even frames only, never ciphered
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      link.pt_msg_vld <= 1'b0;
      link.pt_msg     <= CMC_MSG_STOP_REQ;
    end else begin
      link.pt_msg_vld <= 1'b0;
      if (send_req) begin
        link.pt_msg_vld <= 1'b1;
        link.pt_msg     <= op_stop ? CMC_MSG_STOP_REQ : CMC_MSG_START_REQ;
      end else if (send_grant) begin
        link.pt_msg_vld <= 1'b1;
        link.pt_msg     <= op_stop ? CMC_MSG_STOP_GRANT : CMC_MSG_START_GRANT;
      end
    end
  end

  // ==========================================================
  // Upward events
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mode_switch_confirm_prim_out <= 1'b0;
      link_release_indication_out  <= 1'b0;
    end else begin
      mode_switch_confirm_prim_out <= conf_seen;
      link_release_indication_out  <= timeout;
    end
  end

  // ==========================================================
  // Receive mode and discard window
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rx_decrypt_out <= 1'b0;
      rx_discard_out <= 1'b0;
    end else if (new_connection_in) begin
      rx_decrypt_out <= 1'b0;
      rx_discard_out <= 1'b0;
    end else if (conf_seen) begin
      // Confirm frame is already read in the new mode
      rx_decrypt_out <= !op_stop;
      rx_discard_out <= 1'b0;
    end else if (timeout) begin
      rx_discard_out <= 1'b0;
    end else if (send_req && req_cnt == 3'h0) begin
      rx_discard_out <= 1'b1;
    end
  end

  // ==========================================================
  // Transmit mode, shared by every bearer of the connection
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cipher_on_out <= 1'b0;
    end else if (new_connection_in) begin
      cipher_on_out <= 1'b0;
    end else if (send_grant) begin
      cipher_on_out <= !op_stop;
    end
  end

  // ==========================================================
  // Connection handover tracking
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      handover_leg            <= 1'b0;
      old_conn_release_ok_out <= 1'b0;
    end else if (new_connection_in) begin
      handover_leg            <= 1'b1;
      old_conn_release_ok_out <= 1'b0;
    end else if (handover_leg && send_grant && !op_stop) begin
      // Old leg may go only once this leg is ciphered
      handover_leg            <= 1'b0;
      old_conn_release_ok_out <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= state != PT_IDLE;
    end
  end

  // ==========================================================
  // Keystream setup and B-field mask
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cipher_key_out <= 64'h0;
    end else if (key_load) begin
      cipher_key_out <= new_key_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      init_value_out <= 35'h0;
      ks_apply_out   <= 1'b0;
    end else begin
      // Same frame number on every leg gives one segment pair
      init_value_out <= {7'h00, link.multiframe_num, link.frame_num};
      ks_apply_out   <= cipher_on_out &&
                        cmc_bit_ciphered(bit_idx_in, prot_fmt_in, j_len_in);
    end
  end

endmodule : cmc_portable

`default_nettype wire
